// ### hw/mac_pkg.sv
// Constants and carrier types for the multiply/accumulate accelerator.
// Assumes a 32-bit classic Wishbone slave port; each register takes one aligned word.
package mac_pkg;
    // Word indices; byte address is four times the index
    localparam logic [5:0] IDX_CTRL = 6'h00;
    localparam logic [5:0] IDX_OPA = 6'h01;
    localparam logic [5:0] IDX_OPB = 6'h02;
    localparam logic [5:0] IDX_ACCH = 6'h03;
    localparam logic [5:0] IDX_ACCM = 6'h04;
    localparam logic [5:0] IDX_ACCL = 6'h05;
    // Control register bit positions
    localparam int BIT_UNSIGNED = 0;
    localparam int BIT_ACCUM = 1;
    localparam int BIT_SUBTRACT = 2;
    localparam int BIT_SINGLE = 3;
    localparam int BIT_SQUARE = 4;
    localparam int BIT_CLEAR = 5;
    localparam int BIT_INHIBIT = 6;
    localparam int BIT_OVERFLOW = 7;
    localparam int BIT_QUOTIENT = 8;
    // Reset values
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [47:0] ACC_RESET = 48'h0000_0000_0000;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic quotient_enable;
        logic acc_write_inhibit;
        logic self_product_enable;
        logic single_operand_trigger;
        logic subtract_select;
        logic accumulate_select;
        logic unsigned_select;
    } mac_ctrl_type;

    // Operation selection captured when an operation starts
    typedef struct packed {
        logic acc_write_inhibit;
        logic subtract_select;
        logic accumulate_select;
        logic unsigned_select;
    } mac_op_type;

    localparam mac_ctrl_type CTRL_RESET = '0;
    localparam mac_op_type OP_RESET = '0;
endpackage

// ### hw/mac_product.sv
// Registered 16x16 multiplier with signed or unsigned operands.
// Assumes operands are held stable in the cycle that i_load is high.
`timescale 1ns/1ns
`default_nettype none
module mac_product
    import mac_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Operands
    input wire logic [15:0] i_a,
    input wire logic [15:0] i_b,
    input wire logic i_unsigned,
    input wire logic i_load,
    // Product, extended to accumulator width
    output logic [47:0] o_product
);
    logic [16:0] a_ext;
    logic [16:0] b_ext;
    logic [33:0] full;
    logic [31:0] prod32;

    // Top-bit extension picks two's complement or magnitude
    assign a_ext = {i_a[15] & ~i_unsigned, i_a};
    assign b_ext = {i_b[15] & ~i_unsigned, i_b};
    assign full = $signed(a_ext) * $signed(b_ext);
    assign prod32 = full[31:0];

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_product <= ACC_RESET;
        end else if (i_load) begin
            o_product <= {{16{prod32[31] & ~i_unsigned}}, prod32};
        end
    end
endmodule
`default_nettype wire

// ### hw/mac_accel.sv
// Multiply/accumulate accelerator with control, operand and accumulator registers.
// Assumes a classic Wishbone master with 32-bit data on the single 250 MHz clock.
// Operation
// - Clear command zeroes operands, accumulator, overflow
// - Clear command resets operand sequence immediately
// - Clear command bit returns to zero itself
// - Clear during operation aborts it
// - Writing clear bit zero does nothing
// - Inhibit low: result stored to accumulator
// - Inhibit high: result dropped, accumulator kept
// - Overflow flag set when operation overflowed
// - Overflow cleared by reset, start, clear
// - Control bits 15 to 9 read zero
// - Operands and accumulator reset to zero
// - Operand loading starts multiply or accumulate
// - Operand signedness follows unsigned select
// - Zero means two's complement, one magnitude
// - Two writes needed unless single trigger or square mode
// - Square mode loads both, overrides trigger
// - Accumulator is 48 bits, three words
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module mac_accel
    import mac_pkg::*;
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST,
    // Wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic O_WB_ACK,
    output logic [31:0] O_WB_DAT,
    // Status
    output logic O_BUSY,
    output logic O_OVERFLOW
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_MULT = 3'b010,
        ST_ACCUM = 3'b100
    } mac_state_type;

    mac_state_type state_reg;
    mac_state_type state_next;
    mac_ctrl_type ctrl_reg;
    mac_op_type op_reg;
    logic [15:0] opa_reg;
    logic [15:0] opb_reg;
    logic [47:0] acc_reg;
    logic overflow_reg;
    logic got_a_reg;
    logic got_b_reg;
    logic [47:0] product;
    // Merge a write into a 16-bit register under the byte lane selects
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat, input logic [3:0] sel);
        merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    endfunction
    // Bus decode
    logic req;
    logic wr;
    logic [5:0] idx;
    logic wr_ctrl;
    logic wr_opa;
    logic wr_opb;
    logic wr_acch;
    logic wr_accm;
    logic wr_accl;
    logic wr_acc_any;
    logic clear_cmd;
    logic [15:0] ctrl_wdata;

    assign req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
    assign wr = req & I_WB_WE;
    assign idx = I_WB_ADR[7:2];
    assign wr_ctrl = wr && (idx == IDX_CTRL);
    assign wr_opa = wr && (idx == IDX_OPA);
    assign wr_opb = wr && (idx == IDX_OPB);
    assign wr_acch = wr && (idx == IDX_ACCH);
    assign wr_accm = wr && (idx == IDX_ACCM);
    assign wr_accl = wr && (idx == IDX_ACCL);
    assign wr_acc_any = wr_acch | wr_accm | wr_accl;
    // Procedural so that changes of the stored control bits are seen
    always_comb ctrl_wdata = merge16(ctrl_read(), I_WB_DAT, I_WB_SEL);
    // A one in the clear position triggers; a zero is simply not acted on
    assign clear_cmd = wr_ctrl & I_WB_SEL[0] & I_WB_DAT[BIT_CLEAR];
    // Control word as software sees it; clear bit never stored, upper bits zero
    function automatic logic [15:0] ctrl_read();
        logic [15:0] v;
        v = WORD_RESET;
        v[BIT_UNSIGNED] = ctrl_reg.unsigned_select;
        v[BIT_ACCUM] = ctrl_reg.accumulate_select;
        v[BIT_SUBTRACT] = ctrl_reg.subtract_select;
        v[BIT_SINGLE] = ctrl_reg.single_operand_trigger;
        v[BIT_SQUARE] = ctrl_reg.self_product_enable;
        v[BIT_INHIBIT] = ctrl_reg.acc_write_inhibit;
        v[BIT_OVERFLOW] = overflow_reg;
        v[BIT_QUOTIENT] = ctrl_reg.quotient_enable;
        ctrl_read = v;
    endfunction
    // Operation start decision
    logic op_wr;
    logic start;
    assign op_wr = wr_opa | wr_opb;
    always_comb begin
        start = 1'b0;
        if (op_wr && !clear_cmd) begin
            if (ctrl_reg.self_product_enable || ctrl_reg.single_operand_trigger) begin
                start = 1'b1;
            end else begin
                // Both operands needed; this write completes the pair
                start = (wr_opa && got_b_reg) || (wr_opb && got_a_reg);
            end
        end
    end
    // Control register
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_ctrl) begin
            // Divide enable is held but drives nothing; software keeps it zero
            ctrl_reg.unsigned_select <= ctrl_wdata[BIT_UNSIGNED];
            ctrl_reg.accumulate_select <= ctrl_wdata[BIT_ACCUM];
            ctrl_reg.subtract_select <= ctrl_wdata[BIT_SUBTRACT];
            ctrl_reg.single_operand_trigger <= ctrl_wdata[BIT_SINGLE];
            ctrl_reg.self_product_enable <= ctrl_wdata[BIT_SQUARE];
            ctrl_reg.acc_write_inhibit <= ctrl_wdata[BIT_INHIBIT];
            ctrl_reg.quotient_enable <= ctrl_wdata[BIT_QUOTIENT];
        end
    end
    // Operand registers
    logic [15:0] opa_wdata;
    logic [15:0] opb_wdata;
    assign opa_wdata = merge16(opa_reg, I_WB_DAT, I_WB_SEL);
    assign opb_wdata = merge16(opb_reg, I_WB_DAT, I_WB_SEL);

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            opa_reg <= WORD_RESET;
            opb_reg <= WORD_RESET;
        end else if (clear_cmd) begin
            opa_reg <= WORD_RESET;
            opb_reg <= WORD_RESET;
        end else if (ctrl_reg.self_product_enable && op_wr) begin
            // Square mode writes the same value into both operands
            opa_reg <= wr_opa ? opa_wdata : opb_wdata;
            opb_reg <= wr_opa ? opa_wdata : opb_wdata;
        end else if (wr_opa) begin
            opa_reg <= opa_wdata;
        end else if (wr_opb) begin
            opb_reg <= opb_wdata;
        end
    end
    // Operand sequence counter
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            got_a_reg <= 1'b0;
            got_b_reg <= 1'b0;
        end else if (clear_cmd || start) begin
            got_a_reg <= 1'b0;
            got_b_reg <= 1'b0;
        end else begin
            if (wr_opa) begin
                got_a_reg <= 1'b1;
            end
            if (wr_opb) begin
                got_b_reg <= 1'b1;
            end
        end
    end
    // Operation sequencer: product register, then accumulator update
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: state_next = start ? ST_MULT : ST_IDLE;
            ST_MULT: state_next = ST_ACCUM;
            ST_ACCUM: state_next = start ? ST_MULT : ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
        if (start) begin
            state_next = ST_MULT;
        end
        if (clear_cmd) begin
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end
    // Selection is frozen at start so control writes mid-operation cannot mix modes
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            op_reg <= OP_RESET;
        end else if (start) begin
            op_reg.unsigned_select <= ctrl_reg.unsigned_select;
            op_reg.accumulate_select <= ctrl_reg.accumulate_select;
            op_reg.subtract_select <= ctrl_reg.subtract_select;
            op_reg.acc_write_inhibit <= ctrl_reg.acc_write_inhibit;
        end
    end

    mac_product u_product (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_a(opa_reg),
        .i_b(opb_reg),
        .i_unsigned(op_reg.unsigned_select),
        .i_load(state_reg == ST_MULT),
        .o_product(product)
    );
    // Result and overflow
    logic [48:0] sum;
    logic [47:0] result;
    logic ovf_calc;
    always_comb begin
        sum = {1'b0, product};
        ovf_calc = 1'b0;
        case ({op_reg.subtract_select, op_reg.accumulate_select})
            2'b00: begin
                sum = {1'b0, product};
            end
            2'b01: begin
                sum = {1'b0, acc_reg} + {1'b0, product};
                ovf_calc = op_reg.unsigned_select ? sum[48] :
                    (acc_reg[47] == product[47]) && (sum[47] != acc_reg[47]);
            end
            2'b10: begin
                sum = 49'h0_0000_0000_0000 - {1'b0, product};
                ovf_calc = op_reg.unsigned_select && (product != ACC_RESET);
            end
            2'b11: begin
                sum = {1'b0, acc_reg} - {1'b0, product};
                ovf_calc = op_reg.unsigned_select ? sum[48] :
                    (acc_reg[47] != product[47]) && (sum[47] != acc_reg[47]);
            end
            default: begin
                sum = {1'b0, product};
            end
        endcase
        result = sum[47:0];
    end
    // Accumulator: three 16-bit words, high word holds the sign
    logic finish;
    assign finish = (state_reg == ST_ACCUM) && !clear_cmd;

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            acc_reg <= ACC_RESET;
        end else if (clear_cmd) begin
            acc_reg <= ACC_RESET;
        end else if (wr_acc_any) begin
            // Software write beats a finishing result in the same cycle
            if (wr_acch) begin
                acc_reg[47:32] <= merge16(acc_reg[47:32], I_WB_DAT, I_WB_SEL);
            end
            if (wr_accm) begin
                acc_reg[31:16] <= merge16(acc_reg[31:16], I_WB_DAT, I_WB_SEL);
            end
            if (wr_accl) begin
                acc_reg[15:0] <= merge16(acc_reg[15:0], I_WB_DAT, I_WB_SEL);
            end
        end else if (finish && !op_reg.acc_write_inhibit) begin
            acc_reg <= result;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            overflow_reg <= 1'b0;
        end else if (clear_cmd || start) begin
            overflow_reg <= 1'b0;
        end else if (finish) begin
            overflow_reg <= ovf_calc;
        end
    end
    // Bus answer: one wait-free cycle, ack for every address
    logic [31:0] rdata;
    always_comb begin
        case (idx)
            IDX_CTRL: rdata = {16'h0000, ctrl_read()};
            IDX_OPA: rdata = {16'h0000, opa_reg};
            IDX_OPB: rdata = {16'h0000, opb_reg};
            IDX_ACCH: rdata = {16'h0000, acc_reg[47:32]};
            IDX_ACCM: rdata = {16'h0000, acc_reg[31:16]};
            IDX_ACCL: rdata = {16'h0000, acc_reg[15:0]};
            default: rdata = DATA_ZERO;
        endcase
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_WB_ACK <= 1'b0;
            O_WB_DAT <= DATA_ZERO;
        end else begin
            O_WB_ACK <= req;
            if (req && !I_WB_WE) begin
                O_WB_DAT <= rdata;
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_BUSY <= 1'b0;
            O_OVERFLOW <= 1'b0;
        end else begin
            O_BUSY <= (state_next != ST_IDLE);
            O_OVERFLOW <= (clear_cmd || start) ? 1'b0 : (finish ? ovf_calc : overflow_reg);
        end
    end
    // Checks
    a_clear_zeroes: assert property (@(posedge I_CLK) disable iff (I_RST)
        clear_cmd |=> (opa_reg == WORD_RESET) && (opb_reg == WORD_RESET) && (acc_reg == ACC_RESET) && !overflow_reg)
        else $error("clear left data or overflow set");
    a_clear_sequence: assert property (@(posedge I_CLK) disable iff (I_RST)
        clear_cmd |=> !got_a_reg && !got_b_reg)
        else $error("clear did not reset operand sequence");
    a_clear_selfclr: assert property (@(posedge I_CLK) disable iff (I_RST)
        (req && !I_WB_WE && idx == IDX_CTRL) |=> !O_WB_DAT[BIT_CLEAR])
        else $error("clear bit read back as one");
    a_clear_aborts: assert property (@(posedge I_CLK) disable iff (I_RST)
        (clear_cmd && state_reg != ST_IDLE) |=> (state_reg == ST_IDLE) ##1 (acc_reg == ACC_RESET || $past(wr_acc_any)))
        else $error("clear did not abort operation");
    a_zero_clear_noop: assert property (@(posedge I_CLK) disable iff (I_RST)
        (wr_ctrl && !I_WB_DAT[BIT_CLEAR] && state_reg == ST_IDLE) |=> $stable(acc_reg) && $stable(opa_reg) && $stable(got_a_reg))
        else $error("zero clear bit changed state");
    a_acc_store: assert property (@(posedge I_CLK) disable iff (I_RST)
        (finish && !op_reg.acc_write_inhibit && !wr_acc_any) |=> acc_reg == $past(result))
        else $error("result not stored");
    a_acc_inhibit: assert property (@(posedge I_CLK) disable iff (I_RST)
        (finish && op_reg.acc_write_inhibit && !wr_acc_any) |=> $stable(acc_reg))
        else $error("inhibited result changed accumulator");
    a_overflow_set: assert property (@(posedge I_CLK) disable iff (I_RST)
        (finish && ovf_calc && !start) |=> overflow_reg && O_OVERFLOW)
        else $error("overflow not flagged");
    a_overflow_start: assert property (@(posedge I_CLK) disable iff (I_RST)
        start |=> !overflow_reg ##1 (state_reg == ST_ACCUM || $past(clear_cmd) || $past(start)))
        else $error("start did not clear overflow");
    a_reserved_zero: assert property (@(posedge I_CLK) disable iff (I_RST)
        (req && !I_WB_WE && idx == IDX_CTRL) |=> O_WB_DAT[31:9] == 23'h00_0000)
        else $error("reserved control bits nonzero");
    a_pair_start: assert property (@(posedge I_CLK) disable iff (I_RST)
        (op_wr && !ctrl_reg.self_product_enable && !ctrl_reg.single_operand_trigger && !got_a_reg && !got_b_reg)
        |-> !start)
        else $error("single write started a paired operation");
    a_square_both: assert property (@(posedge I_CLK) disable iff (I_RST)
        (op_wr && ctrl_reg.self_product_enable && !clear_cmd) |=> (opa_reg == opb_reg) && (state_reg == ST_MULT))
        else $error("square mode did not load both operands");
    a_ack_single: assert property (@(posedge I_CLK) disable iff (I_RST)
        req |=> O_WB_ACK ##1 !O_WB_ACK)
        else $error("ack not a single cycle");
    c_mac_done: cover property (@(posedge I_CLK) disable iff (I_RST)
        start ##1 state_reg == ST_MULT ##1 finish && op_reg.accumulate_select);
    c_overflow: cover property (@(posedge I_CLK) disable iff (I_RST) finish && ovf_calc);
    c_abort: cover property (@(posedge I_CLK) disable iff (I_RST) clear_cmd && state_reg != ST_IDLE);
    c_square: cover property (@(posedge I_CLK) disable iff (I_RST) op_wr && ctrl_reg.self_product_enable);
endmodule
`default_nettype wire

// ### verif/mac_wb_host.sv
// Wishbone master standing in for the processor core at the register port.
// Assumes the slave acks every request; a lost ack raises o_hang for the bench.
`timescale 1ns/1ns
`default_nettype none
module mac_wb_host (
    // Clock
    input wire logic i_clk,
    // Wishbone master side
    output logic o_cyc,
    output logic o_stb,
    output logic o_we,
    output logic [7:0] o_adr,
    output logic [3:0] o_sel,
    output logic [31:0] o_dat,
    input wire logic i_ack,
    input wire logic [31:0] i_dat,
    // Lost handshake
    output logic o_hang
);
    initial begin
        o_cyc = 1'b0;
        o_stb = 1'b0;
        o_we = 1'b0;
        o_adr = 8'h00;
        o_sel = 4'h0;
        o_dat = 32'h0000_0000;
        o_hang = 1'b0;
    end

    // Ack is taken at the rising edge where it is sampled high, read data with it;
    // the request is released only then and stays low for one full cycle
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [15:0] d, output logic [31:0] q);
        int n;
        n = 0;
        o_cyc <= 1'b1;
        o_stb <= 1'b1;
        o_we <= we;
        o_adr <= adr;
        o_sel <= 4'h3;
        o_dat <= {16'h0000, d};
        do begin
            @(posedge i_clk);
            n++;
        end while (i_ack !== 1'b1 && n < 50);
        q = i_dat;
        if (i_ack !== 1'b1) begin
            o_hang <= 1'b1;
        end
        o_cyc <= 1'b0;
        o_stb <= 1'b0;
        @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// ### verif/test_mac_accel.sv
// Self-checking bench for the multiply/accumulate accelerator.
// Assumes the host model drives the register port; a reference model predicts every read.
`timescale 1ns/1ns
`default_nettype none
module test_mac_accel
    import mac_pkg::*;
;
    logic clk, rst, cyc, stb, we, ack, busy, ovf_o, hang;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dw, dr;
    logic [15:0] m_a, m_b, m_ctrl;
    logic [47:0] m_acc;
    bit m_ovf, fa, fb;
    int bad_count = 0;
    int cmp_count = 0;
    int busy_cyc = 0;
    localparam longint LIM = 64'sh0001_0000_0000_0000;
    localparam longint HALF = 64'sh0000_8000_0000_0000;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    mac_accel dut (.I_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
        .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dw), .O_WB_ACK(ack), .O_WB_DAT(dr),
        .O_BUSY(busy), .O_OVERFLOW(ovf_o));
    mac_wb_host host (.i_clk(clk), .o_cyc(cyc), .o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel),
        .o_dat(dw), .i_ack(ack), .i_dat(dr), .o_hang(hang));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (bad_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge hang) begin
        bad_count++;
        finish_test();
    end

    // Counts edges at which the busy output is seen high
    always @(posedge clk) begin
        if (busy === 1'b1) begin
            busy_cyc <= busy_cyc + 1;
        end
    end

    function automatic void model_zero();
        m_a = 16'h0000;
        m_b = 16'h0000;
        m_acc = 48'h0000_0000_0000;
        m_ovf = 1'b0;
        fa = 1'b0;
        fb = 1'b0;
    endfunction

    function automatic void model_start();
        longint p, av, r;
        bit u;
        u = m_ctrl[BIT_UNSIGNED];
        p = u ? longint'(m_a) * longint'(m_b) : longint'($signed(m_a)) * longint'($signed(m_b));
        av = u ? longint'(m_acc) : longint'($signed(m_acc));
        case (m_ctrl[2:1])
            2'b00: r = p;
            2'b01: r = av + p;
            2'b10: r = -p;
            default: r = av - p;
        endcase
        m_ovf = u ? (r < 0 || r >= LIM) : (r < -HALF || r >= HALF);
        if (!m_ctrl[BIT_INHIBIT]) begin
            m_acc = r[47:0];
        end
        fa = 1'b0;
        fb = 1'b0;
    endfunction

    // Extra idle cycles let a started operation land before the next access
    task automatic wr(input logic [5:0] idx, input logic [15:0] d);
        logic [31:0] q;
        int n0;
        bit st;
        st = 1'b0;
        n0 = busy_cyc;
        host.xfer(1'b1, {idx, 2'b00}, d, q);
        case (idx)
            IDX_CTRL: begin
                if (d[BIT_CLEAR]) begin
                    model_zero();
                end
                m_ctrl = d & 16'h015F;
            end
            IDX_OPA, IDX_OPB: begin
                if (idx == IDX_OPA || m_ctrl[BIT_SQUARE]) m_a = d;
                if (idx == IDX_OPB || m_ctrl[BIT_SQUARE]) m_b = d;
                if (idx == IDX_OPA) fa = 1'b1;
                else fb = 1'b1;
                st = m_ctrl[BIT_SQUARE] || m_ctrl[BIT_SINGLE] || (fa && fb);
                if (st) model_start();
            end
            IDX_ACCH: m_acc[47:32] = d;
            IDX_ACCM: m_acc[31:16] = d;
            IDX_ACCL: m_acc[15:0] = d;
            default: ;
        endcase
        repeat (2) @(posedge clk);
        // A started operation shows busy for its multiply and accumulate cycles
        check(32'(busy_cyc - n0), st ? 32'h0000_0002 : 32'h0000_0000);
    endtask

    // Reads every register plus one unmapped word
    task automatic check_all();
        logic [31:0] q;
        logic [15:0] e;
        for (int i = 0; i < 7; i++) begin
            host.xfer(1'b0, {i[5:0], 2'b00}, 16'h0000, q);
            case (i)
                0: e = {7'h00, m_ctrl[8], m_ovf, m_ctrl[6], 1'b0, m_ctrl[4:0]};
                1: e = m_a;
                2: e = m_b;
                3: e = m_acc[47:32];
                4: e = m_acc[31:16];
                5: e = m_acc[15:0];
                default: e = 16'h0000;
            endcase
            check(q, {16'h0000, e});
        end
        check(32'(ovf_o), 32'(m_ovf));
        check(32'(busy), 32'h0000_0000);
    endtask

    initial begin
        logic [15:0] c, a, b;
        logic [15:0] hi [4] = '{16'h7FFF, 16'h8000, 16'hFFFF, 16'h0000};
        rst = 1'b1;
        void'($urandom(28781));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        model_zero();
        m_ctrl = 16'h0000;
        @(posedge clk);
        check_all();
        for (int i = 0; i < 96; i++) begin
            c = 16'($urandom) & 16'hFE00;
            c[4:0] = i[4:0];
            c[BIT_INHIBIT] = i[5] && (i[2:1] == 2'b00);
            a = (i % 3 == 0) ? 16'h8000 : 16'($urandom);
            b = (i % 5 == 0) ? 16'hFFFF : 16'($urandom);
            wr(IDX_ACCH, (i % 2 == 0) ? hi[(i / 2) % 4] : 16'($urandom));
            wr(IDX_ACCM, 16'($urandom));
            wr(IDX_CTRL, c);
            wr(IDX_OPA, a);
            wr(IDX_OPB, b);
            check_all();
        end
        wr(IDX_CTRL, 16'h0000);
        wr(IDX_OPA, 16'h0003);
        wr(IDX_OPA, 16'h0005);
        check_all();
        wr(IDX_CTRL, 16'h0000);
        wr(IDX_OPB, 16'h0007);
        check_all();
        wr(IDX_ACCH, 16'h7FFF);
        wr(IDX_ACCM, 16'hFFFF);
        wr(IDX_ACCL, 16'hFFFF);
        wr(IDX_CTRL, 16'h0002);
        wr(IDX_OPA, 16'h7FFF);
        wr(IDX_OPB, 16'h7FFF);
        check_all();
        wr(IDX_OPA, 16'h0001);
        wr(IDX_CTRL, 16'h0022);
        check_all();
        wr(IDX_OPB, 16'h0009);
        check_all();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        model_zero();
        m_ctrl = 16'h0000;
        @(posedge clk);
        check_all();
        finish_test();
    end
endmodule
`default_nettype wire
